// ===== common/ppsel_pkg.sv
// constants for the peripheral input pin-select block
package ppsel_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int SEL_W = 8;
    // register offsets on the plain register port
    localparam logic [7:0] SYNC_SEL_OFS = 8'h00;
    localparam logic [7:0] LEVEL_OFS = 8'h01;
    localparam logic [7:0] GEN_SEL_BASE = 8'h10;
    // field positions
    localparam int SYNC_FIELD_LSB = 8;
    localparam int LO_FIELD_LSB = 0;
    localparam int HI_FIELD_LSB = 8;
    // reset values
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // pin numbering: 0 is ground, 1..175 pads, 176..181 virtual
    localparam logic [7:0] PIN_GROUND = 8'h00;
    localparam int NUM_PADS = 175;
    localparam int VPIN_FIRST = 176;
    localparam int NUM_VPINS = 6;
    localparam int PIN_COUNT = VPIN_FIRST + NUM_VPINS;
    localparam logic [7:0] PIN_LAST = 8'hb5;
    // synchroniser depth for pad inputs
    localparam int SYNC_STAGES = 2;
endpackage : ppsel_pkg

// ===== src/ppsel_pin_mux.sv
// one selection mux: picks the pin named by a selection field
`timescale 1ns/1ps
module ppsel_pin_mux
    import ppsel_pkg::*;
(
    input wire logic [SEL_W-1:0] sel, // selection field value
    input wire logic [PIN_COUNT-1:0] pins, // pin levels, bit n is pin n
    output logic level // routed level
);
    wire inRange;
    wire isGround;

    assign isGround = (sel == PIN_GROUND);
    // out-of-range codes are invalid; ground them rather than index past the vector
    assign inRange = (sel <= PIN_LAST);
    assign level = (!isGround && inRange) ? pins[sel] : 1'b0;
endmodule : ppsel_pin_mux

// ===== src/ppsel_input_select.sv
// peripheral input pin-select: selection registers and routing
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module ppsel_input_select
    import ppsel_pkg::*;
#(
    parameter int NUM_GEN_REGS = 2 // general select registers, two fields each
)
(
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic nrst, // synchronous reset, active low
    input wire logic [ppsel_pkg::ADDR_W-1:0] regAddr, // register address
    input wire logic [ppsel_pkg::DATA_W-1:0] regWrData, // register write data
    input wire logic regWr, // write strobe, one cycle
    input wire logic regRd, // read strobe, one cycle
    output logic [ppsel_pkg::DATA_W-1:0] regRdData, // read data, cycle after strobe
    input wire logic [ppsel_pkg::NUM_PADS-1:0] padIn, // pad levels, bit i is pin i+1
    input wire logic [ppsel_pkg::NUM_VPINS-1:0] virtIn, // peripheral outputs on pins 176..
    output logic [2*NUM_GEN_REGS:0] periphIn // routed inputs; bit 0 is pwm sync 1
);
    import ppsel_pkg::*;

    localparam int NUM_INPUTS = 2 * NUM_GEN_REGS + 1;

    // pad synchroniser, two stages
    logic [NUM_PADS-1:0] padMeta_ff;
    logic [NUM_PADS-1:0] padSync_ff;

    // selection fields, index 0 is the pwm sync 1 source
    logic [SEL_W-1:0] selField_ff [NUM_INPUTS];
    logic [SEL_W-1:0] nxt_selField [NUM_INPUTS];

    logic [NUM_INPUTS-1:0] routed;
    logic [NUM_INPUTS-1:0] periphIn_ff;
    logic [DATA_W-1:0] regRdData_ff;
    logic [DATA_W-1:0] nxt_regRdData;

    wire [PIN_COUNT-1:0] pinVec;
    wire syncHit;
    wire levelHit;
    wire [NUM_GEN_REGS-1:0] genHit;
    wire [DATA_W-1:0] syncRead;
    wire [DATA_W-1:0] levelRead;
    wire [DATA_W-1:0] genRead [NUM_GEN_REGS];

    // pads are asynchronous to clk_sys
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            padMeta_ff <= '0;
            padSync_ff <= '0;
        end else begin
            padMeta_ff <= padIn;
            padSync_ff <= padMeta_ff;
        end
    end

    // pin vector: ground, synchronised pads, then virtual pins fed only by peripherals
    assign pinVec[0] = 1'b0;
    assign pinVec[NUM_PADS:1] = padSync_ff;
    // virtual pins take no pad and drive no pad; they loop peripheral outputs back
    assign pinVec[PIN_COUNT-1:VPIN_FIRST] = virtIn;

    // address decode
    assign syncHit = (regAddr == SYNC_SEL_OFS);
    assign levelHit = (regAddr == LEVEL_OFS);

    genvar g;
    generate
        for (g = 0; g < NUM_GEN_REGS; g++) begin : gen_dec
            assign genHit[g] = (regAddr == GEN_SEL_BASE + 8'(g));
            assign genRead[g] = {selField_ff[2*g+2], selField_ff[2*g+1]};
        end
    endgenerate

    // sync register: field in the high byte, low byte unimplemented
    assign syncRead = {selField_ff[0], 8'h00};
    assign levelRead = DATA_W'(periphIn_ff);

    // next field values: a write touches only the fields of the addressed register
    always_comb begin
        for (int i = 0; i < NUM_INPUTS; i++) begin
            nxt_selField[i] = selField_ff[i];
        end
        if (regWr && syncHit) begin
            nxt_selField[0] = regWrData[SYNC_FIELD_LSB +: SEL_W];
        end
        for (int k = 0; k < NUM_GEN_REGS; k++) begin
            if (regWr && genHit[k]) begin
                nxt_selField[2*k+1] = regWrData[LO_FIELD_LSB +: SEL_W];
                nxt_selField[2*k+2] = regWrData[HI_FIELD_LSB +: SEL_W];
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        nxt_regRdData = REG_RESET;
        if (regRd) begin
            if (syncHit) begin
                nxt_regRdData = syncRead;
            end else if (levelHit) begin
                nxt_regRdData = levelRead;
            end
            for (int k = 0; k < NUM_GEN_REGS; k++) begin
                if (genHit[k]) begin
                    nxt_regRdData = genRead[k];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                selField_ff[i] <= SEL_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                selField_ff[i] <= nxt_selField[i];
            end
        end
    end

    // one mux per peripheral input; codes above the last pin ground the input
    generate
        for (g = 0; g < NUM_INPUTS; g++) begin : gen_mux
            ppsel_pin_mux u_mux (
                .sel(selField_ff[g]),
                .pins(pinVec),
                .level(routed[g])
            );
        end
    endgenerate

    // registered outputs: one cycle from field or virtual pin change to the peripheral, three from a pad change
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            periphIn_ff <= '0;
            regRdData_ff <= REG_RESET;
        end else begin
            periphIn_ff <= routed;
            regRdData_ff <= nxt_regRdData;
        end
    end

    assign periphIn = periphIn_ff;
    assign regRdData = regRdData_ff;
endmodule : ppsel_input_select

// ===== testbench/ppsel_properties.sv
// checker for pin-select registers and routing
`timescale 1ns/1ps
module ppsel_properties
    import ppsel_pkg::*;
#(parameter int NUM_GEN_REGS = 2)
(
    input wire logic clk_sys, // clock
    input wire logic nrst, // reset
    input wire logic [ppsel_pkg::ADDR_W-1:0] regAddr, // address
    input wire logic [ppsel_pkg::DATA_W-1:0] regWrData, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    input wire logic [ppsel_pkg::DATA_W-1:0] regRdData, // read data
    input wire logic [ppsel_pkg::NUM_PADS-1:0] padIn, // pads
    input wire logic [ppsel_pkg::NUM_VPINS-1:0] virtIn, // virtual pins
    input wire logic [2*NUM_GEN_REGS:0] periphIn // routed inputs
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire logic syncWr = regWr && regAddr == SYNC_SEL_OFS;
    wire logic [7:0] code = regWrData[15:8];
    a_rd_idle: assert property (!regRd |=> regRdData == 16'h0000) else $error("stray read data");
    a_sync_low: assert property (regRd && regAddr == SYNC_SEL_OFS |=> regRdData[7:0] == 8'h00)
        else $error("sync low byte not zero");
    a_wr_rd: assert property (syncWr ##1 regRd && regAddr == SYNC_SEL_OFS
        |=> regRdData[15:8] == $past(regWrData[15:8], 2)) else $error("sync field readback");
    a_gnd_sel: assert property (syncWr && code == 8'h00 |-> ##2 !periphIn[0])
        else $error("ground select not low");
    a_bad_gnd: assert property (syncWr && code > PIN_LAST |-> ##2 !periphIn[0])
        else $error("invalid select not grounded");
    a_virt_pin: assert property (syncWr && code == PIN_LAST ##1 !syncWr
        |=> periphIn[0] == $past(virtIn[5])) else $error("virtual pin not routed");
    a_pad_pin: assert property (syncWr && code == 8'h01 ##1 !syncWr [*3]
        |=> periphIn[0] == $past(padIn[0], 3)) else $error("pad pin not routed");
    a_level_rd: assert property (regRd && regAddr == LEVEL_OFS
        |=> regRdData == 16'($past(periphIn))) else $error("level readback");
    cover property (syncWr ##1 regRd);
    cover property (regRd && regAddr == LEVEL_OFS);
    cover property (periphIn[0] ##1 !periphIn[0]);
endmodule : ppsel_properties
bind ppsel_input_select ppsel_properties #(.NUM_GEN_REGS(NUM_GEN_REGS)) u_chk (.clk_sys,
    .nrst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .padIn, .virtIn, .periphIn);

// ===== testbench/ppsel_far_model.sv
// far side: pad drivers and peripheral outputs on virtual pins
`timescale 1ns/1ps
module ppsel_far_model
    import ppsel_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic [ppsel_pkg::NUM_PADS-1:0] padSet, // wanted pad levels
    input wire logic [ppsel_pkg::NUM_VPINS-1:0] virtSet, // wanted peripheral outputs
    output logic [ppsel_pkg::NUM_PADS-1:0] padIn, // pad levels
    output logic [ppsel_pkg::NUM_VPINS-1:0] virtIn // outputs placed on virtual pins
);
    // virtual pins kept apart from pads, driven from on-chip flops
    always_ff @(posedge clk_sys) begin
        padIn <= padSet;
        virtIn <= virtSet;
    end
endmodule : ppsel_far_model

// ===== testbench/tb_top.sv
// testbench: random and corner pin selections via the register port
`timescale 1ns/1ps
module tb_top;
    import ppsel_pkg::*;
    logic clk_sys = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, pend = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000, regRdData, pexp = 16'h0000;
    logic [NUM_PADS-1:0] padSet = '0, padIn;
    logic [5:0] virtSet = 6'h00, virtIn;
    logic [4:0] periphIn, e;
    logic [7:0] c [5];
    logic [7:0] cn [8] = '{8'h00, 8'h01, 8'haf, 8'hb0, 8'hb5, 8'hb6, 8'hff, 8'h02};
    logic [31:0] r = 32'h36b15640;
    int fails = 0, check_count = 0;
    always #5 clk_sys = ~clk_sys;
    ppsel_far_model i_far (.clk_sys, .padSet, .virtSet, .padIn, .virtIn);
    ppsel_input_select #(.NUM_GEN_REGS(2)) i_dut (.clk_sys, .nrst, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData, .padIn, .virtIn, .periphIn);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic pin(input logic [7:0] n, input logic [174:0] p, input logic [5:0] v);
        if (n == 8'h00 || n > 8'hb5) return 1'b0;
        if (n >= 8'hb0) return v[n - 8'hb0];
        return p[n - 8'h01];
    endfunction : pin
    // read data is checked one call later, when it stands
    task bus(input logic w, input logic rd, input logic [7:0] a, input logic [15:0] d, x);
        @(posedge clk_sys);
        regWr <= w;
        regRd <= rd;
        regAddr <= a;
        regWrData <= d;
        #1;
        check_count++;
        if (regRdData !== (pend ? pexp : 16'h0000)) begin
            fails++;
            $display("wrong value at %0t: read data %h", $time, regRdData);
        end
        pend = rd;
        pexp = x;
    endtask : bus
    task results;
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        bus(1'b0, 1'b1, GEN_SEL_BASE, 16'h0, 16'h0);
        for (int k = 0; k < 24; k++) begin
            for (int i = 0; i < 5; i++) begin
                r = lfsr(r);
                c[i] = k < 8 ? cn[(k + i) % 8] : r[7:0];
            end
            padSet <= 175'({6{r}});
            virtSet <= r[13:8];
            bus(1'b1, 1'b0, SYNC_SEL_OFS, {c[0], r[7:0]}, 16'h0);
            bus(1'b0, 1'b1, SYNC_SEL_OFS, 16'h0, {c[0], 8'h00});
            bus(1'b1, 1'b0, GEN_SEL_BASE, {c[2], c[1]}, 16'h0);
            bus(1'b1, 1'b0, 8'h11, {c[4], c[3]}, 16'h0);
            bus(1'b1, 1'b0, 8'h40, r[15:0], 16'h0);
            repeat (5) bus(1'b0, 1'b0, 8'h00, 16'h0, 16'h0);
            for (int i = 0; i < 5; i++) e[i] = pin(c[i], padSet, virtSet);
            check_count++;
            if (periphIn !== e) begin
                fails++;
                $display("wrong value at %0t: routed %b", $time, periphIn);
            end
            bus(1'b0, 1'b1, LEVEL_OFS, 16'h0, {11'h000, e});
            bus(1'b0, 1'b1, 8'h11, 16'h0, {c[4], c[3]});
            bus(1'b0, 1'b1, 8'h40, 16'h0, 16'h0);
        end
        bus(1'b0, 1'b0, 8'h00, 16'h0, 16'h0);
        results();
    end
    // thirteen cycles per round, about 318 in all, so over twelve times the need
    initial begin
        repeat (4000) @(posedge clk_sys);
        fails++;
        results();
    end
endmodule : tb_top
